// >>> rtl/dac_defs.svh
// Register map, field positions, reset values and timing of the DAC block.
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define DAC_OFS_CODE0      4'h0
`define DAC_OFS_CODE1      4'h4
`define DAC_OFS_CTRL       4'h8
`define DAC_OFS_STBY       4'hC

// ==========================================================================
// Field positions
`define DAC_CTRL_OE1_BIT   7
`define DAC_CTRL_OE0_BIT   6
`define DAC_CTRL_JOINT_BIT 5
`define DAC_STBY_KEEP_BIT  0

// ==========================================================================
// Reset values and fixed read-back bits
`define DAC_CODE_RST       8'h00
`define DAC_CTRL_RST       8'h1F
`define DAC_STBY_RST       8'hFE
`define DAC_CTRL_ONES      5'h1F
`define DAC_STBY_ONES      7'h7F

// ==========================================================================
// Timing
`define DAC_CONV_TIME_NS   10000
`define DAC_CLK_PERIOD_NS  100
`define DAC_CONV_CYCLES    (`DAC_CONV_TIME_NS / `DAC_CLK_PERIOD_NS)

`endif

// >>> rtl/dac_pkg.sv
// Types shared by the DAC control block.
package dac_pkg;
  typedef logic [7:0] dac_code_t;
  typedef enum logic [1:0] {
    DAC_CH_IDLE,
    DAC_CH_CONV,
    DAC_CH_HOLD
  } dac_ch_state_t;
endpackage : dac_pkg

// >>> rtl/dac_field_reg.sv
// Software register field with a hardware clear that beats a write.
`timescale 1ns/10ps
module dac_field_reg #(
  parameter int       W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         clear,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] q
);
  generate
    if (W < 1) begin : g_bad_width
      $error("dac_field_reg: width must be at least one");
    end
  endgenerate

  // Standby entry wins over a write landing in the same cycle.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= RST;
    end else if (clear) begin
      q <= RST;
    end else if (wr_en) begin
      q <= wdata;
    end
  end
endmodule : dac_field_reg

// >>> rtl/dac_channel.sv
// One conversion channel: settling timer, result hold and valid flag.
`timescale 1ns/10ps
`include "dac_defs.svh"
module dac_channel #(
  parameter int CONV_CYCLES = `DAC_CONV_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              conv_en,
  input  wire dac_pkg::dac_code_t code,
  output dac_pkg::dac_code_t     result_reg,
  output logic                   valid_reg
);
  import dac_pkg::*;

  localparam int CW = $clog2(CONV_CYCLES + 1);

  generate
    if (CONV_CYCLES < 1) begin : g_bad_cycles
      $error("dac_channel: conversion needs at least one cycle");
    end
  endgenerate

  dac_ch_state_t state_reg;
  dac_code_t     conv_code_reg;
  logic [CW-1:0] cnt_reg;
  logic          start;

  // A fresh enable or a new code restarts the settling time.
  assign start = conv_en &&
                 (state_reg == DAC_CH_IDLE || code != conv_code_reg);

  // ========================================================================
  // Sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= DAC_CH_IDLE;
      cnt_reg       <= '0;
      conv_code_reg <= '0;
    end else if (!conv_en) begin
      state_reg <= DAC_CH_IDLE;
      cnt_reg   <= '0;
    end else if (start) begin
      state_reg     <= DAC_CH_CONV;
      cnt_reg       <= CW'(CONV_CYCLES);
      conv_code_reg <= code;
    end else begin
      case (state_reg)
        DAC_CH_CONV: begin
          if (cnt_reg == CW'(1)) begin
            state_reg <= DAC_CH_HOLD;
          end
          cnt_reg <= cnt_reg - CW'(1);
        end
        DAC_CH_HOLD: state_reg <= DAC_CH_HOLD;
        default:     state_reg <= DAC_CH_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Result and valid flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      result_reg <= '0;
      valid_reg  <= 1'b0;
    end else if (!conv_en || start) begin
      valid_reg <= 1'b0;
    end else if (state_reg == DAC_CH_CONV && cnt_reg == CW'(1)) begin
      result_reg <= conv_code_reg;
      valid_reg  <= 1'b1;
    end
  end

  // ========================================================================
  // Checks
  property p_valid_late;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(valid_reg) |-> $past(cnt_reg) == CW'(1) && $past(conv_en);
  endproperty
  a_valid_late: assert property (p_valid_late)
    else $error("valid rose before the conversion time ran out");

  property p_code_restart;
    @(posedge clk_sys) disable iff (!resetn)
      conv_en && state_reg == DAC_CH_HOLD && code != conv_code_reg
      |=> !valid_reg;
  endproperty
  a_code_restart: assert property (p_code_restart)
    else $error("code change did not restart conversion");

  property p_hold;
    @(posedge clk_sys) disable iff (!resetn)
      valid_reg && conv_en && code == conv_code_reg
      |=> valid_reg && $stable(result_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held result changed without cause");
endmodule : dac_channel

// >>> rtl/dac_dual_ctrl.sv
// Two-channel 8-bit DAC control with an APB register slave.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "dac_defs.svh"

module dac_dual_ctrl #(
  parameter int APB_AW      = 8,
  parameter int CONV_CYCLES = `DAC_CONV_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sw_standby,
  input  wire logic              hw_standby,
  output dac_pkg::dac_code_t     analog_out_ch0,
  output logic                   analog_out_ch0_oe_n,
  output logic                   ch0_valid,
  output dac_pkg::dac_code_t     analog_out_ch1,
  output logic                   analog_out_ch1_oe_n,
  output logic                   ch1_valid
);
  import dac_pkg::*;

  localparam logic [7:0] CTRL_RST = `DAC_CTRL_RST;
  localparam logic [7:0] STBY_RST = `DAC_STBY_RST;

  generate
    if (APB_AW < 5) begin : g_bad_aw
      $error("dac_dual_ctrl: APB address needs at least five bits");
    end
  endgenerate

  // ==========================================================================
  // APB decode
  logic       setup;
  logic       access;
  logic       hit;
  logic       wr_ok;
  logic       err_reg;
  logic [3:0] ofs;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign ofs    = paddr[3:0];
  assign hit    = (paddr[APB_AW-1:4] == '0) &&
                  (ofs == `DAC_OFS_CODE0 || ofs == `DAC_OFS_CODE1 ||
                   ofs == `DAC_OFS_CTRL  || ofs == `DAC_OFS_STBY);
  // Registers are byte wide, so only lane 0 can change them.
  assign wr_ok  = access && pwrite && !err_reg && pstrb[0];
  assign pready  = 1'b1;
  assign pslverr = access && err_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      err_reg <= 1'b0;
    end else if (setup) begin
      err_reg <= !hit;
    end
  end

  // ==========================================================================
  // Standby handling
  logic sw_standby_q;
  logic sw_entry;
  logic keep;
  logic clr_main;
  logic out_allowed;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sw_standby_q <= 1'b0;
    end else begin
      sw_standby_q <= sw_standby;
    end
  end

  assign sw_entry = sw_standby && !sw_standby_q;
  // Hardware standby always clears; software entry only without keep.
  assign clr_main = hw_standby || (sw_entry && !keep);
  // Outputs stay live in software standby only when keep is set.
  assign out_allowed = !hw_standby && (!sw_standby || keep);

  // ==========================================================================
  // Registers
  dac_code_t  code0;
  dac_code_t  code1;
  logic [2:0] ctrl_bits;
  logic       stby_bit;
  logic       oe0;
  logic       oe1;
  logic       joint;

  dac_field_reg #(.W(8), .RST(`DAC_CODE_RST)) u_code0 (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (clr_main),
    .wr_en   (wr_ok && ofs == `DAC_OFS_CODE0),
    .wdata   (pwdata[7:0]),
    .q       (code0)
  );

  dac_field_reg #(.W(8), .RST(`DAC_CODE_RST)) u_code1 (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (clr_main),
    .wr_en   (wr_ok && ofs == `DAC_OFS_CODE1),
    .wdata   (pwdata[7:0]),
    .q       (code1)
  );

  // Only bits 7..5 are stored; the low bits are constant ones.
  dac_field_reg #(.W(3), .RST(CTRL_RST[7:5])) u_ctrl (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (clr_main),
    .wr_en   (wr_ok && ofs == `DAC_OFS_CTRL),
    .wdata   (pwdata[7:5]),
    .q       (ctrl_bits)
  );

  // Software standby never touches this register.
  dac_field_reg #(.W(1), .RST(STBY_RST[0])) u_stby (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (hw_standby),
    .wr_en   (wr_ok && ofs == `DAC_OFS_STBY),
    .wdata   (pwdata[`DAC_STBY_KEEP_BIT]),
    .q       (stby_bit)
  );

  assign oe1   = ctrl_bits[`DAC_CTRL_OE1_BIT - 5];
  assign oe0   = ctrl_bits[`DAC_CTRL_OE0_BIT - 5];
  assign joint = ctrl_bits[`DAC_CTRL_JOINT_BIT - 5];
  assign keep  = stby_bit;

  // ==========================================================================
  // Read data
  logic [7:0] rd_mux;

  always_comb begin
    case (ofs)
      `DAC_OFS_CODE0: rd_mux = code0;
      `DAC_OFS_CODE1: rd_mux = code1;
      `DAC_OFS_CTRL:  rd_mux = {ctrl_bits, `DAC_CTRL_ONES};
      `DAC_OFS_STBY:  rd_mux = {`DAC_STBY_ONES, stby_bit};
      default:        rd_mux = 8'h00;
    endcase
  end

  // Captured in the setup cycle so prdata comes from a flop.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= hit ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Conversion gating
  logic conv0;
  logic conv1;

  // Joint mode lets either enable start both converters.
  assign conv0 = out_allowed && (oe0 || (joint && oe1));
  assign conv1 = out_allowed && (oe1 || (joint && oe0));

  dac_channel #(.CONV_CYCLES(CONV_CYCLES)) u_ch0 (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .conv_en    (conv0),
    .code       (code0),
    .result_reg (analog_out_ch0),
    .valid_reg  (ch0_valid)
  );

  dac_channel #(.CONV_CYCLES(CONV_CYCLES)) u_ch1 (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .conv_en    (conv1),
    .code       (code1),
    .result_reg (analog_out_ch1),
    .valid_reg  (ch1_valid)
  );

  // ==========================================================================
  // Pin drive
  // The pin is released as soon as its own enable drops, whatever joint is.
  assign analog_out_ch0_oe_n = !(out_allowed && oe0);
  assign analog_out_ch1_oe_n = !(out_allowed && oe1);

  // ==========================================================================
  // Checks
  property p_sw_clear;
    @(posedge clk_sys) disable iff (!resetn)
      sw_standby && !sw_standby_q && !stby_bit
      |=> code0 == 8'h00 && code1 == 8'h00 && ctrl_bits == 3'h0;
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("codes not cleared on software standby entry");

  property p_sw_keep;
    @(posedge clk_sys) disable iff (!resetn)
      sw_standby && !sw_standby_q && stby_bit && !hw_standby && !access
      |=> $stable(code0) && $stable(code1) && $stable(ctrl_bits);
  endproperty
  a_sw_keep: assert property (p_sw_keep)
    else $error("registers lost on software standby with keep set");

  property p_hw_clear;
    @(posedge clk_sys) disable iff (!resetn)
      hw_standby |=> ctrl_bits == 3'h0 && !stby_bit && code0 == 8'h00;
  endproperty
  a_hw_clear: assert property (p_hw_clear)
    else $error("hardware standby did not reset the registers");

  // Read data was taken at the setup edge, so compare with the bits then.
  property p_ctrl_ones;
    @(posedge clk_sys) disable iff (!resetn)
      access && !pwrite && !err_reg && ofs == `DAC_OFS_CTRL
      |-> prdata[4:0] == 5'h1F && prdata[7:5] == $past(ctrl_bits);
  endproperty
  a_ctrl_ones: assert property (p_ctrl_ones)
    else $error("control low bits did not read as ones");

  property p_stby_ones;
    @(posedge clk_sys) disable iff (!resetn)
      access && !pwrite && !err_reg && ofs == `DAC_OFS_STBY
      |-> prdata[7:1] == 7'h7F;
  endproperty
  a_stby_ones: assert property (p_stby_ones)
    else $error("standby register high bits did not read as ones");

  property p_joint;
    @(posedge clk_sys) disable iff (!resetn)
      out_allowed && joint && (oe0 || oe1) |-> conv0 && conv1;
  endproperty
  a_joint: assert property (p_joint)
    else $error("joint mode did not enable both converters");

  property p_all_off;
    @(posedge clk_sys) disable iff (!resetn)
      !oe0 && !oe1 |=> !ch0_valid && !ch1_valid;
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("a channel stayed valid with both enables low");

  property p_own_pin;
    @(posedge clk_sys) disable iff (!resetn)
      !oe0 |-> analog_out_ch0_oe_n;
  endproperty
  a_own_pin: assert property (p_own_pin)
    else $error("channel 0 pin driven with its enable clear");

  property p_stby_release;
    @(posedge clk_sys) disable iff (!resetn)
      sw_standby && !stby_bit |-> analog_out_ch0_oe_n && analog_out_ch1_oe_n;
  endproperty
  a_stby_release: assert property (p_stby_release)
    else $error("output driven in software standby without keep");

  property p_write_lands;
    @(posedge clk_sys) disable iff (!resetn)
      wr_ok && ofs == `DAC_OFS_CODE1 && !clr_main
      |=> code1 == $past(pwdata[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("channel 1 code write was lost");

  property p_unmapped;
    @(posedge clk_sys) disable iff (!resetn)
      setup && !hit |=> !penable || pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access completed without an error");

  property p_oe1_pin;
    @(posedge clk_sys) disable iff (!resetn)
      !oe1 |-> analog_out_ch1_oe_n;
  endproperty
  a_oe1_pin: assert property (p_oe1_pin)
    else $error("channel 1 pin driven with its enable clear");

  property p_drive0;
    @(posedge clk_sys) disable iff (!resetn)
      out_allowed && oe0 |-> !analog_out_ch0_oe_n;
  endproperty
  a_drive0: assert property (p_drive0)
    else $error("channel 0 pin not driven with its enable set");

  property p_drive1;
    @(posedge clk_sys) disable iff (!resetn)
      out_allowed && oe1 |-> !analog_out_ch1_oe_n;
  endproperty
  a_drive1: assert property (p_drive1)
    else $error("channel 1 pin not driven with its enable set");

  property p_ch1_solo;
    @(posedge clk_sys) disable iff (!resetn)
      out_allowed && !joint && oe1 && !oe0 |-> conv1 && !conv0;
  endproperty
  a_ch1_solo: assert property (p_ch1_solo)
    else $error("channel 0 converted without its own enable");

  property p_ctrl_write;
    @(posedge clk_sys) disable iff (!resetn)
      wr_ok && ofs == `DAC_OFS_CTRL && !clr_main
      |=> ctrl_bits == $past(pwdata[7:5]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control enable write was lost");

  // Software standby entry must leave this bit alone whatever keep says.
  property p_stby_hold;
    @(posedge clk_sys) disable iff (!resetn)
      !hw_standby && !(wr_ok && ofs == `DAC_OFS_STBY)
      |=> $stable(stby_bit);
  endproperty
  a_stby_hold: assert property (p_stby_hold)
    else $error("standby register changed without a write");

  property p_code0_write;
    @(posedge clk_sys) disable iff (!resetn)
      wr_ok && ofs == `DAC_OFS_CODE0 && !clr_main
      |=> code0 == $past(pwdata[7:0]);
  endproperty
  a_code0_write: assert property (p_code0_write)
    else $error("channel 0 code write was lost");
endmodule : dac_dual_ctrl

// >>> tb/dac_pin_model.sv
// Pin-side model of one analog output: follows the code or shows its inverse.
`timescale 1ns/10ps
module dac_pin_model (
  input  wire logic [7:0] code,
  input  wire logic       oe_n,
  output logic      [7:0] pin_level
);
  // ========================================
  // Pin level
  // A released pin shows the inverted code, so a stale code never passes.
  // The level follows at once, as an analog pin has no clock of its own.
  assign pin_level = (oe_n === 1'b0) ? code : ~code;
endmodule : dac_pin_model

// >>> tb/dac_dual_ctrl_test.sv
// Self-checking bench for the two-channel DAC control block.
`timescale 1ns/10ps
module dac_dual_ctrl_test;
  import dac_pkg::*;
  localparam int         CONV   = 4;
  localparam int         LIMIT  = 64;
  localparam logic [7:0] AD_C0  = 8'h00;
  localparam logic [7:0] AD_C1  = 8'h04;
  localparam logic [7:0] AD_CTL = 8'h08;
  localparam logic [7:0] AD_STB = 8'h0C;
  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic        sw_standby, hw_standby, rerr;
  logic [7:0]  paddr, pin0, pin1;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb;
  dac_code_t   out0, out1;
  logic        oe0_n, oe1_n, valid0, valid1;
  int          num_errors, check_count;

  dac_dual_ctrl #(.CONV_CYCLES(CONV)) u_dac_dual_ctrl (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_standby(sw_standby), .hw_standby(hw_standby),
    .analog_out_ch0(out0), .analog_out_ch0_oe_n(oe0_n), .ch0_valid(valid0),
    .analog_out_ch1(out1), .analog_out_ch1_oe_n(oe1_n), .ch1_valid(valid1)
  );
  dac_pin_model u_dac_pin_model_ch0 (
    .code(out0), .oe_n(oe0_n), .pin_level(pin0)
  );
  dac_pin_model u_dac_pin_model_ch1 (
    .code(out1), .oe_n(oe1_n), .pin_level(pin1)
  );

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // ========================================
  // Reporting
  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk_pin

  // ========================================
  // APB master
  // Each transfer idles one cycle first, so no signal is set twice at once.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < LIMIT);
    if (n >= LIMIT) begin
      num_errors++;
      print_verdict();
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'hF);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a,
                    input logic [7:0] e);
    apb(1'b0, a, 32'h0, 4'hF);
    chk_reg(n, {24'h0, e}, rdata);
    chk_pin("slverr", 1'b0, rerr);
  endtask : rd

  // Counts falling edges until the channel's valid flag is seen high.
  task automatic wait_valid(input bit ch, input int e);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while ((ch ? valid1 : valid0) !== 1'b1 && n < LIMIT);
    if (n >= LIMIT) begin
      num_errors++;
      print_verdict();
    end
    chk_reg("conversion cycles", e, n);
  endtask : wait_valid

  // ========================================
  // Main sequence
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
    sw_standby = 1'b0; hw_standby = 1'b0;
    num_errors = 0; check_count = 0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    rd("code0", AD_C0, 8'h00);
    rd("code1", AD_C1, 8'h00);
    rd("control", AD_CTL, 8'h1F);
    rd("standby", AD_STB, 8'hFE);
    chk_pin("oe0_n", 1'b1, oe0_n);
    chk_pin("oe1_n", 1'b1, oe1_n);
    wr(AD_CTL, 8'h00);
    rd("control", AD_CTL, 8'h1F);
    wr(AD_STB, 8'h00);
    rd("standby", AD_STB, 8'hFE);
    wr(AD_STB, 8'h01);
    rd("standby", AD_STB, 8'hFF);
    wr(AD_STB, 8'h00);
    apb(1'b1, AD_C0, 32'h99, 4'h0);
    rd("code0", AD_C0, 8'h00);
    apb(1'b0, 8'h10, 32'h0, 4'hF);
    chk_pin("unmapped err", 1'b1, rerr);
    chk_reg("unmapped data", 32'h0, rdata);
    wr(AD_C0, 8'h5A);
    wr(AD_CTL, 8'h40);
    wait_valid(1'b0, CONV + 2);
    chk_reg("out0", 32'h5A, {24'h0, out0});
    chk_reg("pin0", 32'h5A, {24'h0, pin0});
    chk_pin("oe1_n", 1'b1, oe1_n);
    chk_pin("valid1", 1'b0, valid1);
    wr(AD_C0, 8'hA5);
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk_pin("valid0", 1'b0, valid0);
    wait_valid(1'b0, CONV);
    chk_reg("out0", 32'hA5, {24'h0, out0});
    wr(AD_C1, 8'h33);
    wr(AD_CTL, 8'h60);
    wait_valid(1'b1, CONV + 2);
    chk_reg("out1", 32'h33, {24'h0, out1});
    chk_pin("oe1_n", 1'b1, oe1_n);
    chk_pin("valid0", 1'b1, valid0);
    wr(AD_CTL, 8'h20);
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk_pin("valid0", 1'b0, valid0);
    chk_pin("valid1", 1'b0, valid1);
    chk_pin("oe0_n", 1'b1, oe0_n);
    chk_reg("out0", 32'hA5, {24'h0, out0});
    chk_reg("pin0", 32'h5A, {24'h0, pin0});
    wr(AD_CTL, 8'hA0);
    wait_valid(1'b0, CONV + 2);
    chk_pin("oe0_n", 1'b1, oe0_n);
    chk_pin("valid1", 1'b1, valid1);
    wr(AD_CTL, 8'h20);
    wr(AD_CTL, 8'h80);
    wait_valid(1'b1, CONV + 2);
    chk_pin("oe1_n", 1'b0, oe1_n);
    chk_pin("valid0", 1'b0, valid0);
    chk_reg("pin1", 32'h33, {24'h0, pin1});
    wr(AD_CTL, 8'hC0);
    wait_valid(1'b0, CONV + 2);
    chk_pin("valid1", 1'b1, valid1);
    @(posedge clk_sys);
    sw_standby <= 1'b1;
    rd("code0", AD_C0, 8'h00);
    rd("control", AD_CTL, 8'h1F);
    chk_pin("oe0_n", 1'b1, oe0_n);
    @(posedge clk_sys);
    sw_standby <= 1'b0;
    wr(AD_STB, 8'h01);
    wr(AD_C0, 8'h77);
    wr(AD_CTL, 8'hC0);
    @(posedge clk_sys);
    sw_standby <= 1'b1;
    rd("code0", AD_C0, 8'h77);
    rd("control", AD_CTL, 8'hDF);
    rd("standby", AD_STB, 8'hFF);
    chk_pin("oe0_n", 1'b0, oe0_n);
    chk_pin("oe1_n", 1'b0, oe1_n);
    @(posedge clk_sys);
    sw_standby <= 1'b0;
    @(posedge clk_sys);
    hw_standby <= 1'b1;
    @(posedge clk_sys);
    hw_standby <= 1'b0;
    rd("standby", AD_STB, 8'hFE);
    rd("code0", AD_C0, 8'h00);
    rd("control", AD_CTL, 8'h1F);
    chk_pin("oe0_n", 1'b1, oe0_n);
    print_verdict();
  end
endmodule : dac_dual_ctrl_test
